// >>> design/pm_phy_regs_map.vh
// Offsets, bit positions and reset values of the power-management
// and PHY output control configuration registers.
// Assumes byte offsets within a 256-byte configuration space.
`ifndef PM_PHY_REGS_MAP_VH
`define PM_PHY_REGS_MAP_VH

// Configuration offsets
`define PM_CSR_OFF       8'h48
`define PM_EXT_OFF       8'h4a
`define PHY_CTRL_OFF     8'hec
`define MISC_CFG_OFF     8'hf0

// Dword index slice of a byte offset
`define DW_MSB           7
`define DW_LSB           2

// Byte lanes
`define LANE_LO          0
`define LANE_HI          1

// Power-management control/status fields
`define WAKE_STS_BIT     15
`define WAKE_EN_BIT      8
`define PWR_LVL_MSB      1
`define PWR_LVL_LSB      0

// PHY output control fields
`define ROUTE_BIT        7
`define COMPLY_BIT       3

// Unpowered-wake capability in the miscellaneous register
`define CAP_BIT          15

// Reset values
`define PWR_LVL_RST      2'h0
`define WAKE_STS_RST     1'h0
`define WAKE_EN_RST      1'h0
`define ROUTE_RST        1'h0
`define COMPLY_RST       1'h1
`define CAP_RST          1'h0
`define WAKE_OE_N_RST    1'h1
`define SYNC_RST         1'h0
`define CNA_OUT_RST      1'h0
`define RDATA_RST        32'h0000_0000

`endif

// >>> design/pm_phy_regs.v
// Power-management control/status, extension and PHY output control
// configuration registers, plus the unpowered-wake capability bit.
// Assumes a one-cycle configuration access strobe on the PCI clock,
// a power-on reset for sticky state, and the PHY indicator arriving
// from another clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "pm_phy_regs_map.vh"

module pm_phy_regs
(
	input  wire        clock_i,
	input  wire        srst_i,
	input  wire        por_i,
	input  wire        d3hot_rst_i,
	input  wire        cfg_wr_i,
	input  wire        cfg_rd_i,
	input  wire [7:0]  cfg_addr_i,
	input  wire [3:0]  cfg_be_i,
	input  wire [31:0] cfg_wdata_i,
	output reg  [31:0] cfg_rdata_o,
	input  wire        wake_event_i,
	output wire        wake_pme_o,
	output reg         wake_pme_oe_n_o,
	input  wire        eeprom_load_i,
	input  wire [7:0]  eeprom_byte_i,
	input  wire        cable_activity_indicator_i,
	output reg         cable_activity_out_o,
	output wire [1:0]  power_level_o,
	output wire        wake_from_unpowered_cap_o
);

	// Dword match; the byte lane picks the half
	function dw_hit;
		input [7:0] addr;
		input [7:0] off;
		begin
			dw_hit = (addr[`DW_MSB:`DW_LSB] == off[`DW_MSB:`DW_LSB]);
		end
	endfunction

	reg        wake_sts_q;
	reg        wake_sts_d;
	reg        wake_en_q;
	reg        wake_en_d;
	reg  [1:0] pwr_lvl_q;
	reg  [1:0] pwr_lvl_d;
	reg        route_q;
	reg        route_d;
	reg        comply_q;
	reg        comply_d;
	reg        cap_q;
	reg        cap_d;
	reg        cna_meta_q;
	reg        cna_sync_q;
	reg [31:0] rdata_d;
	reg        oe_n_d;

	wire       hit_csr;
	wire       hit_phy;
	wire       hit_misc;
	wire       wr_csr_lo;
	wire       wr_csr_hi;
	wire       wr_phy_lo;
	wire       wr_misc_hi;
	wire       sts_clear;

	assign hit_csr    = dw_hit(cfg_addr_i, `PM_CSR_OFF);
	assign hit_phy    = dw_hit(cfg_addr_i, `PHY_CTRL_OFF);
	assign hit_misc   = dw_hit(cfg_addr_i, `MISC_CFG_OFF);

	// lane gated writes
	// Only lanes holding writable bits are decoded at all
	assign wr_csr_lo  = cfg_wr_i & hit_csr & cfg_be_i[`LANE_LO];
	assign wr_csr_hi  = cfg_wr_i & hit_csr & cfg_be_i[`LANE_HI];
	assign wr_phy_lo  = cfg_wr_i & hit_phy & cfg_be_i[`LANE_LO];
	assign wr_misc_hi = cfg_wr_i & hit_misc & cfg_be_i[`LANE_HI];

	assign sts_clear  = wr_csr_hi & cfg_wdata_i[`WAKE_STS_BIT];

	// Open-drain wake line only ever pulls low
	assign wake_pme_o = 1'h0;

	assign power_level_o = pwr_lvl_q;
	assign wake_from_unpowered_cap_o = cap_q;

	always @*
	begin
		wake_sts_d = wake_sts_q;
		// set regardless of enable
		// Set beats a clear in the same cycle, so no event is lost
		if (wake_event_i)
		begin
			wake_sts_d = 1'h1;
		end
		else if (sts_clear)
		begin
			wake_sts_d = 1'h0;
		end
	end

	always @*
	begin
		wake_en_d = wake_en_q;
		pwr_lvl_d = pwr_lvl_q;
		if (wr_csr_hi)
		begin
			wake_en_d = cfg_wdata_i[`WAKE_EN_BIT];
		end
		if (wr_csr_lo)
		begin
			pwr_lvl_d = cfg_wdata_i[`PWR_LVL_MSB:`PWR_LVL_LSB];
		end
	end

	always @*
	begin
		route_d  = route_q;
		comply_d = comply_q;
		cap_d    = cap_q;
		// other EEPROM bits dropped
		// Load wins over a coincident write; it happens once after reset
		if (eeprom_load_i)
		begin
			route_d  = eeprom_byte_i[`ROUTE_BIT];
			comply_d = eeprom_byte_i[`COMPLY_BIT];
		end
		else if (wr_phy_lo)
		begin
			route_d  = cfg_wdata_i[`ROUTE_BIT];
			comply_d = cfg_wdata_i[`COMPLY_BIT];
		end
		if (wr_misc_hi)
		begin
			cap_d = cfg_wdata_i[`CAP_BIT];
		end
	end

	// sticky when capable
	// Power-on reset clears everything; bus reset spares sticky bits
	always @(posedge clock_i)
	begin
		if (por_i)
		begin
			wake_sts_q <= `WAKE_STS_RST;
			wake_en_q  <= `WAKE_EN_RST;
			pwr_lvl_q  <= `PWR_LVL_RST;
			cap_q      <= `CAP_RST;
		end
		else if (srst_i)
		begin
			pwr_lvl_q <= `PWR_LVL_RST;
			if (!cap_q)
			begin
				wake_sts_q <= `WAKE_STS_RST;
				wake_en_q  <= `WAKE_EN_RST;
			end
			else
			begin
				wake_sts_q <= wake_sts_d;
				wake_en_q  <= wake_en_q;
			end
		end
		else
		begin
			wake_sts_q <= wake_sts_d;
			wake_en_q  <= wake_en_d;
			pwr_lvl_q  <= pwr_lvl_d;
			cap_q      <= cap_d;
		end
	end

	always @(posedge clock_i)
	begin
		if (por_i || srst_i || d3hot_rst_i)
		begin
			route_q  <= `ROUTE_RST;
			comply_q <= `COMPLY_RST;
		end
		else
		begin
			route_q  <= route_d;
			comply_q <= comply_d;
		end
	end

	always @*
	begin
		oe_n_d = ~(wake_sts_d & wake_en_d);
		// Sticky bits keep the line through a bus reset; others drop it
		if (srst_i && cap_q)
		begin
			oe_n_d = ~(wake_sts_d & wake_en_q);
		end
		else if (srst_i)
		begin
			oe_n_d = `WAKE_OE_N_RST;
		end
	end

	// Registered so the open-drain enable never glitches
	always @(posedge clock_i)
	begin
		if (por_i)
		begin
			wake_pme_oe_n_o <= `WAKE_OE_N_RST;
		end
		else
		begin
			wake_pme_oe_n_o <= oe_n_d;
		end
	end

	// Indicator comes from the PHY clock domain
	always @(posedge clock_i)
	begin
		if (por_i || srst_i)
		begin
			cna_meta_q <= `SYNC_RST;
			cna_sync_q <= `SYNC_RST;
		end
		else
		begin
			cna_meta_q <= cable_activity_indicator_i;
			cna_sync_q <= cna_meta_q;
		end
	end

	// route to terminal
	// Output trails the pin by three clocks: two synchroniser stages plus the output flop
	always @(posedge clock_i)
	begin
		if (por_i || srst_i || d3hot_rst_i)
		begin
			cable_activity_out_o <= `CNA_OUT_RST;
		end
		else
		begin
			cable_activity_out_o <= route_q & cna_sync_q;
		end
	end

	// upper bits zero
	// Unmapped dwords read as zero
	always @*
	begin
		rdata_d = `RDATA_RST;
		if (hit_csr)
		begin
			rdata_d[`WAKE_STS_BIT] = wake_sts_q;
			rdata_d[`WAKE_EN_BIT]  = wake_en_q;
			rdata_d[`PWR_LVL_MSB:`PWR_LVL_LSB] = pwr_lvl_q;
		end
		else if (hit_phy)
		begin
			rdata_d[`ROUTE_BIT]  = route_q;
			rdata_d[`COMPLY_BIT] = comply_q;
		end
		else if (hit_misc)
		begin
			rdata_d[`CAP_BIT] = cap_q;
		end
	end

	// Read data held until the next read or a bus or power-on reset
	always @(posedge clock_i)
	begin
		if (por_i || srst_i)
		begin
			cfg_rdata_o <= `RDATA_RST;
		end
		else if (cfg_rd_i)
		begin
			cfg_rdata_o <= rdata_d;
		end
	end

endmodule // pm_phy_regs

`default_nettype wire

// >>> sim/pm_phy_regs_checker.sv
// Port assertions for the configuration register block.
// Assumes one access strobe at a time, bound inside the block.
`timescale 1ns/100ps
`default_nettype none
module pm_phy_regs_checker
(
	input wire logic        clock_i,
	input wire logic        srst_i,
	input wire logic        por_i,
	input wire logic        d3hot_rst_i,
	input wire logic        cfg_wr_i,
	input wire logic        cfg_rd_i,
	input wire logic [7:0]  cfg_addr_i,
	input wire logic [3:0]  cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	input wire logic [31:0] cfg_rdata_o,
	input wire logic        wake_event_i,
	input wire logic        wake_pme_oe_n_o,
	input wire logic        cable_activity_indicator_i,
	input wire logic        cable_activity_out_o,
	input wire logic [1:0]  power_level_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i || por_i);
	wire rd48 = cfg_rd_i && cfg_addr_i[7:2] == 6'h12;
	wire rdec = cfg_rd_i && cfg_addr_i[7:2] == 6'h3b;
	wire wr48 = cfg_wr_i && cfg_addr_i[7:2] == 6'h12;
	wire [1:0] lvl_w = cfg_wdata_i[1:0];
	// Reset may drop the line too, so it counts as a cause
	wire cause = wake_event_i || cfg_wr_i || srst_i;
	sequence clr_wr;
		wr48 && cfg_be_i[1] && cfg_wdata_i[15] && !wake_event_i;
	endsequence
	sequence ev_rd;
		wake_event_i ##1 !cfg_wr_i [*2] ##1 rd48;
	endsequence
	a_ext_zero: assert property (rd48 |=> cfg_rdata_o[31:16] == 16'h0)
		else $error("extension half not zero");
	a_csr_rsvd: assert property (rd48 |=> cfg_rdata_o[14:9] == 6'h0
		&& cfg_rdata_o[7:2] == 6'h0)
		else $error("status reserved bits not zero");
	a_phy_rsvd: assert property (rdec |=> cfg_rdata_o[31:8] == 24'h0
		&& cfg_rdata_o[6:4] == 3'h0 && cfg_rdata_o[2:0] == 3'h0)
		else $error("phy control reserved bits not zero");
	a_level_write: assert property (wr48 && cfg_be_i[0]
		|=> power_level_o == $past(lvl_w)) else $error("level not written");
	a_level_read: assert property (rd48
		|=> cfg_rdata_o[1:0] == $past(power_level_o))
		else $error("level read wrong");
	a_clear_release: assert property (clr_wr |=> wake_pme_oe_n_o)
		else $error("wake line held after clear");
	a_wake_cause: assert property ($fell(wake_pme_oe_n_o)
		|-> $past(cause) || $past(cause, 2)) else $error("wake without cause");
	a_status_set: assert property (ev_rd |=> cfg_rdata_o[15])
		else $error("wake status not set");
	a_route_cause: assert property (cable_activity_out_o
		|-> $past(cable_activity_indicator_i, 3)) else $error("stray cable out");
	a_d3hot_keep: assert property (d3hot_rst_i && !cfg_wr_i
		|=> $stable(power_level_o)) else $error("level lost on d3hot");
endmodule // pm_phy_regs_checker
bind pm_phy_regs pm_phy_regs_checker u_chk (.*);
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the configuration register block.
// Assumes the block's one-cycle read latency and strobe contract.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        clock_i = 0, srst_i = 1, por_i = 1, d3hot_rst_i = 0;
	logic        cfg_wr_i = 0, cfg_rd_i = 0, wake_event_i = 0;
	logic        eeprom_load_i = 0, cable_activity_indicator_i = 0;
	// EEPROM image keeps reserved bits zero
	logic [7:0]  cfg_addr_i = '0, eeprom_byte_i = 8'h88;
	logic [3:0]  cfg_be_i = '0;
	logic [31:0] cfg_wdata_i = '0, cfg_rdata_o, r;
	logic        wake_pme_o, wake_pme_oe_n_o, cable_activity_out_o;
	logic        wake_from_unpowered_cap_o;
	logic [1:0]  power_level_o;
	integer      bad_count = 0, samples_checked = 0, seed = 80990, i;
	pm_phy_regs u_dut (
		.clock_i                    (clock_i),
		.srst_i                     (srst_i),
		.por_i                      (por_i),
		.d3hot_rst_i                (d3hot_rst_i),
		.cfg_wr_i                   (cfg_wr_i),
		.cfg_rd_i                   (cfg_rd_i),
		.cfg_addr_i                 (cfg_addr_i),
		.cfg_be_i                   (cfg_be_i),
		.cfg_wdata_i                (cfg_wdata_i),
		.cfg_rdata_o                (cfg_rdata_o),
		.wake_event_i               (wake_event_i),
		.wake_pme_o                 (wake_pme_o),
		.wake_pme_oe_n_o            (wake_pme_oe_n_o),
		.eeprom_load_i              (eeprom_load_i),
		.eeprom_byte_i              (eeprom_byte_i),
		.cable_activity_indicator_i (cable_activity_indicator_i),
		.cable_activity_out_o       (cable_activity_out_o),
		.power_level_o              (power_level_o),
		.wake_from_unpowered_cap_o  (wake_from_unpowered_cap_o)
	);
	// Expected dword at 48h from status, enable and level
	function automatic logic [31:0] csr_exp(input logic s, input logic n,
		input logic [1:0] l);
		csr_exp = {16'h0, s, 6'h0, n, 6'h0, l};
	endfunction
	initial forever #5 clock_i = ~clock_i;
	task summarize;
		if (bad_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task acc(input logic w, input logic [7:0] a,
		input logic [3:0] b, input logic [31:0] d);
		@(posedge clock_i);
		cfg_wr_i <= w;
		cfg_rd_i <= !w;
		cfg_addr_i <= a;
		cfg_be_i <= b;
		cfg_wdata_i <= d;
		@(posedge clock_i);
		cfg_wr_i <= 0;
		cfg_rd_i <= 0;
		#1 r = cfg_rdata_o;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		acc(0, a, 4'hf, '0);
		chk(r, e);
	endtask
	// Extra edge lets registered outputs settle before sampling
	// 0 wake event, 1 EEPROM load, 2 D3hot reset, other bus reset
	task pul(input int k);
		@(posedge clock_i);
		case (k)
			0: wake_event_i <= 1;
			1: eeprom_load_i <= 1;
			2: d3hot_rst_i <= 1;
			default: srst_i <= 1;
		endcase
		@(posedge clock_i);
		{wake_event_i, eeprom_load_i, d3hot_rst_i, srst_i} <= '0;
		@(posedge clock_i);
		#1;
	endtask
	initial
	begin
		#200000 bad_count++;
		summarize;
	end
	initial
	begin
		repeat (8) @(posedge clock_i);
		srst_i <= 0;
		por_i <= 0;
		rdc(8'h48, '0);
		rdc(8'hec, 32'h8);
		rdc(8'h10, '0);
		chk(wake_pme_o, 0);
		for (i = 0; i < 4; i++)
		begin
			r = $random(seed);
			acc(1, 8'h48, 4'hf, {r[31:9], 1'h1, r[7:2], i[1:0]});
			rdc(8'h4a, csr_exp(1'h0, 1'h1, i[1:0]));
			chk(power_level_o, i);
		end
		pul(0);
		chk(wake_pme_oe_n_o, 0);
		rdc(8'h48, 32'h8103);
		acc(1, 8'h48, 4'h2, 32'h100);
		rdc(8'h48, 32'h8103);
		acc(1, 8'h48, 4'h2, 32'h8100);
		rdc(8'h48, 32'h103);
		chk(wake_pme_oe_n_o, 1);
		fork
			acc(1, 8'h48, 4'h2, 32'h8100);
			pul(0);
		join
		rdc(8'h48, csr_exp(1'h1, 1'h1, 2'h3));
		acc(1, 8'h48, 4'h2, '0);
		pul(0);
		chk(wake_pme_oe_n_o, 1);
		rdc(8'h48, 32'h8003);
		acc(1, 8'hec, 4'hf, '0);
		rdc(8'hec, '0);
		pul(1);
		rdc(8'hec, 32'h88);
		@(posedge clock_i);
		cable_activity_indicator_i <= 1;
		repeat (4) @(posedge clock_i);
		#1 chk(cable_activity_out_o, 1);
		pul(2);
		chk(cable_activity_out_o, 0);
		rdc(8'hec, 32'h8);
		rdc(8'h48, 32'h8003);
		acc(1, 8'hec, 4'hf, '1);
		rdc(8'hec, 32'h88);
		acc(1, 8'hf0, 4'hf, 32'h8000);
		rdc(8'hf0, 32'h8000);
		chk(wake_from_unpowered_cap_o, 1);
		acc(1, 8'h48, 4'h2, 32'h100);
		pul(3);
		rdc(8'h48, 32'h8100);
		chk(wake_pme_oe_n_o, 0);
		acc(1, 8'hf0, 4'hf, '0);
		pul(3);
		rdc(8'h48, '0);
		chk(wake_pme_oe_n_o, 1);
		chk(wake_from_unpowered_cap_o, 0);
		summarize;
	end
endmodule // tb_top
`default_nettype wire
